// File: logic/interval_timer_consts.svh
// Constants of the interval timer host interface
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH
`define PORT_CONFIG 2'h3
`define CFG_SEL_MSB 7
`define CFG_SEL_LSB 6
`define CFG_RW_MSB 5
`define CFG_RW_LSB 4
`define CFG_MODE_MSB 3
`define CFG_MODE_LSB 1
`define CFG_BCD_BIT 0
`define RW_LATCH 2'h0
`define RW_LOW 2'h1
`define RW_HIGH 2'h2
`define RW_BOTH 2'h3
`define SEL_READBACK 2'h3
`define CFG_RESET 8'h00
`define COUNT_RESET 16'h0000
`endif

// File: logic/interval_timer_pkg.sv
// Types of the interval timer host interface
package interval_timer_pkg;
  typedef enum logic [1:0] {PHASE_LOW, PHASE_HIGH} byte_phase_t;
  typedef struct packed {
    logic [7:0] config_word;
    logic [15:0] initial_count_holding;
    logic [15:0] count;
    logic [15:0] count_snapshot_latch;
    logic held;
    logic pending_load;
    logic load_strobe;
    logic out;
    logic armed;
    byte_phase_t wr_phase;
    byte_phase_t rd_phase;
    logic [7:0] status_latch;
    logic status_held;
    logic prev_clk;
    logic prev_gate;
    logic gate_edge;
  } channel_state_t;
endpackage

// File: logic/timer_channel.sv
// One counting channel with snapshot and status latches
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"
module timer_channel (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_data,
  input wire logic latch_cmd,
  input wire logic status_cmd,
  input wire logic count_we,
  input wire logic count_re,
  input wire logic [7:0] wdata,
  input wire logic tick_clk,
  input wire logic gate,
  output logic out,
  output logic [7:0] rdata
);
  interval_timer_pkg::channel_state_t s;
  interval_timer_pkg::channel_state_t next_s;
  logic [1:0] rw;
  logic [2:0] mode;
  logic tick;
  logic [15:0] dec;
  logic [15:0] reload;
  logic count_done;
  logic [3:0] d0;
  logic [3:0] d1;
  logic [3:0] d2;
  logic [3:0] d3;

  assign rw = s.config_word[`CFG_RW_MSB:`CFG_RW_LSB];
  assign mode = s.config_word[`CFG_MODE_MSB:`CFG_MODE_LSB];
  assign tick = tick_clk && !s.prev_clk;

  // ****************
  // Down counter step
  // ****************
  always_comb begin
    d0 = s.count[3:0];
    d1 = s.count[7:4];
    d2 = s.count[11:8];
    d3 = s.count[15:12];
    if (s.config_word[`CFG_BCD_BIT]) begin
      if (d0 != 4'h0) begin
        d0 = d0 - 4'h1;
      end else begin
        d0 = 4'h9;
        if (d1 != 4'h0) begin
          d1 = d1 - 4'h1;
        end else begin
          d1 = 4'h9;
          if (d2 != 4'h0) begin
            d2 = d2 - 4'h1;
          end else begin
            d2 = 4'h9;
            d3 = (d3 != 4'h0) ? d3 - 4'h1 : 4'h9;
          end
        end
      end
      dec = {d3, d2, d1, d0};
    end else begin
      dec = s.count - 16'h0001;
    end
  end

  assign reload = s.initial_count_holding;
  // A write that completes a new count; its load request must survive a same-cycle load
  assign count_done = count_we && (rw != `RW_BOTH || s.wr_phase == interval_timer_pkg::PHASE_HIGH);

  always_comb begin
    next_s = s;
    next_s.prev_clk = tick_clk;
    next_s.prev_gate = gate;
    if (gate && !s.prev_gate) begin
      next_s.gate_edge = 1'b1;
    end
    // Configuration word
    if (cfg_we) begin
      next_s.config_word = cfg_data;
      next_s.out = (cfg_data[`CFG_MODE_MSB:`CFG_MODE_LSB] == 3'h0) ? 1'b0 : 1'b1;
      next_s.held = 1'b0;
      next_s.status_held = 1'b0;
      next_s.pending_load = 1'b1;
      next_s.armed = 1'b0;
      next_s.wr_phase = interval_timer_pkg::PHASE_LOW;
      next_s.rd_phase = interval_timer_pkg::PHASE_LOW;
      next_s.initial_count_holding = `COUNT_RESET;
      next_s.load_strobe = 1'b0;
    end
    // Initial count bytes
    if (count_we) begin
      unique case (rw)
        `RW_LOW: begin
          next_s.initial_count_holding = {8'h00, wdata};
          next_s.load_strobe = 1'b1;
        end
        `RW_HIGH: begin
          next_s.initial_count_holding = {wdata, 8'h00};
          next_s.load_strobe = 1'b1;
        end
        default: begin
          if (s.wr_phase == interval_timer_pkg::PHASE_LOW) begin
            next_s.initial_count_holding[7:0] = wdata;
            next_s.load_strobe = 1'b0;
            next_s.wr_phase = interval_timer_pkg::PHASE_HIGH;
            if (mode == 3'h0) begin
              next_s.out = 1'b0;
            end
          end else begin
            next_s.initial_count_holding[15:8] = wdata;
            next_s.wr_phase = interval_timer_pkg::PHASE_LOW;
            next_s.load_strobe = 1'b1;
          end
        end
      endcase
      next_s.pending_load = 1'b1;
      if (mode == 3'h0) begin
        next_s.out = 1'b0;
      end
    end
    // Counting element
    if (tick) begin
      next_s.gate_edge = gate && !s.prev_gate;
      if (s.load_strobe && !(mode == 3'h1 || mode == 3'h5)) begin
        next_s.count = reload;
        if (!count_done) begin
          next_s.load_strobe = 1'b0;
        end
        if (!count_we) begin
          next_s.pending_load = 1'b0;
        end
        next_s.armed = 1'b1;
        if (mode[1:0] == 2'h1) begin
          next_s.out = 1'b1;
        end
      end else if ((mode == 3'h1 || mode == 3'h5) && s.gate_edge &&
                   s.pending_load == 1'b0 || (mode == 3'h1 || mode == 3'h5) &&
                   s.gate_edge && s.load_strobe) begin
        next_s.count = reload;
        if (!count_done) begin
          next_s.load_strobe = 1'b0;
        end
        if (!count_we) begin
          next_s.pending_load = 1'b0;
        end
        next_s.armed = 1'b1;
        next_s.out = (mode == 3'h1) ? 1'b0 : 1'b1;
      end else if (gate || mode == 3'h1 || mode == 3'h5) begin
        next_s.count = dec;
        unique case (mode)
          3'h0, 3'h1: begin
            if (s.count == 16'h0001 && s.armed) begin
              next_s.out = 1'b1;
              next_s.armed = 1'b0;
            end
          end
          3'h4, 3'h5: begin
            next_s.out = !(s.count == 16'h0001 && s.armed);
            if (s.count == 16'h0001) begin
              next_s.armed = 1'b0;
            end
          end
          3'h2, 3'h6: begin
            next_s.out = (s.count != 16'h0002);
            if (s.count == 16'h0001) begin
              next_s.count = reload;
            end
          end
          default: begin
            if (s.count <= 16'h0002) begin
              next_s.out = !s.out;
              next_s.count = reload;
            end
          end
        endcase
      end
    end
    // Snapshot latch and status latch
    if (!s.held) begin
      next_s.count_snapshot_latch = next_s.count;
    end
    if (latch_cmd && !s.held) begin
      next_s.held = 1'b1;
      next_s.count_snapshot_latch = s.count;
    end
    if (status_cmd && !s.status_held) begin
      next_s.status_latch = {s.out, s.pending_load, s.config_word[5:0]};
      next_s.status_held = 1'b1;
    end
    if (count_re) begin
      if (s.status_held) begin
        next_s.status_held = 1'b0;
      end else if (rw == `RW_BOTH && s.rd_phase == interval_timer_pkg::PHASE_LOW) begin
        next_s.rd_phase = interval_timer_pkg::PHASE_HIGH;
      end else begin
        next_s.rd_phase = interval_timer_pkg::PHASE_LOW;
        next_s.held = 1'b0;
      end
    end
  end

  // One byte, the status latch or a snapshot byte, drives the read path at a time
  always_comb begin
    if (s.status_held) begin
      rdata = s.status_latch;
    end else if (rw == `RW_HIGH ||
                 (rw == `RW_BOTH && s.rd_phase == interval_timer_pkg::PHASE_HIGH)) begin
      rdata = s.count_snapshot_latch[15:8];
    end else begin
      rdata = s.count_snapshot_latch[7:0];
    end
  end

  assign out = s.out;

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

// File: logic/interval_timer_host_interface.sv
// Host interface of the three channel interval timer
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_consts.svh"
module interval_timer_host_interface #(
  parameter int CHANNELS = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [1:0] PORT_SELECT,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  input wire logic [CHANNELS-1:0] TICK_CLK,
  input wire logic [CHANNELS-1:0] GATE,
  output logic [CHANNELS-1:0] OUT
);
  generate
    if (CHANNELS != 3) begin : g_bad_channels
      $error("Three channels only");
    end
  endgenerate

  typedef struct packed {
    logic prev_rd;
    logic prev_wr;
    logic [1:0] rd_port;
    logic [7:0] data_out;
  } host_state_t;

  host_state_t h;
  host_state_t next_h;
  logic rd_start;
  logic wr_start;
  logic rd_active;
  logic rd_end;
  logic [1:0] sel;
  logic [1:0] rw;
  logic [7:0] rdata [CHANNELS];

  // ****************
  // Strobe qualify
  // ****************
  assign rd_active = !CS_N && !RD_N;
  assign rd_start = rd_active && h.prev_rd;
  // Read ends when strobe or select drops, even if both drop together
  assign rd_end = !rd_active && !h.prev_rd;
  assign wr_start = !CS_N && !WR_N && h.prev_wr;
  assign sel = DATA_IN[`CFG_SEL_MSB:`CFG_SEL_LSB];
  assign rw = DATA_IN[`CFG_RW_MSB:`CFG_RW_LSB];

  // ****************
  // Channels
  // ****************
  generate
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      logic is_cfg;
      logic is_port;
      logic is_rb;
      assign is_port = (PORT_SELECT == 2'(i));
      assign is_cfg = wr_start && PORT_SELECT == `PORT_CONFIG && sel == 2'(i);
      assign is_rb = wr_start && PORT_SELECT == `PORT_CONFIG && sel == `SEL_READBACK
                     && DATA_IN[i+1];
      timer_channel u_ch (
        .clk(CLK),
        .reset(RESET),
        .cfg_we(is_cfg && rw != `RW_LATCH),
        .cfg_data(DATA_IN),
        .latch_cmd((is_cfg && rw == `RW_LATCH) || (is_rb && !DATA_IN[5])),
        .status_cmd(is_rb && !DATA_IN[4]),
        .count_we(wr_start && is_port),
        .count_re(rd_end && h.rd_port == 2'(i)),
        .wdata(DATA_IN),
        .tick_clk(TICK_CLK[i]),
        .gate(GATE[i]),
        .out(OUT[i]),
        .rdata(rdata[i])
      );
    end
  endgenerate

  // ****************
  // Data bus buffer
  // ****************
  always_comb begin
    next_h = h;
    next_h.prev_rd = !rd_active;
    next_h.prev_wr = CS_N || WR_N;
    if (rd_start) begin
      next_h.rd_port = PORT_SELECT;
      // Configuration port is write-only and reads as zero
      next_h.data_out = (PORT_SELECT == `PORT_CONFIG) ? 8'h00 : rdata[PORT_SELECT];
    end
  end

  assign DATA_OUT = h.data_out;
  assign DATA_OE = rd_active;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      h <= '{prev_rd: 1'b1, prev_wr: 1'b1, rd_port: 2'h0, data_out: 8'h00};
    end else begin
      h <= next_h;
    end
  end
endmodule
`default_nettype wire

// File: test/interval_timer_host_interface_properties.sv
// Checker of the interval timer host interface
`timescale 1ns/1ps
`default_nettype none
module interval_timer_host_interface_properties #(
  parameter int CHANNELS = 3
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [1:0] PORT_SELECT,
  input wire logic [7:0] DATA_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE,
  input wire logic [CHANNELS-1:0] TICK_CLK,
  input wire logic [CHANNELS-1:0] GATE,
  input wire logic [CHANNELS-1:0] OUT
);
  // ****
  // Helpers
  // ****
  logic rd_q;
  logic [CHANNELS-1:0] tick_q;
  logic [3:0] quiet;
  wire logic start = !CS_N && !RD_N && !rd_q;
  wire logic cfg_wr = !CS_N && !WR_N && PORT_SELECT == 2'h3;
  always_ff @(posedge CLK) begin
    rd_q <= !CS_N && !RD_N;
    tick_q <= TICK_CLK;
    if (RESET || TICK_CLK != tick_q || !WR_N) quiet <= 4'h0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ****
  // Assertions
  // ****
  oe_needs_cs_a: assert property (CS_N |-> !DATA_OE)
    else $error("Bus driven while deselected");
  oe_on_read_a: assert property (!CS_N && !RD_N |-> DATA_OE)
    else $error("Bus not driven during read");
  oe_released_a: assert property (RD_N |-> !DATA_OE)
    else $error("Bus driven without read strobe");
  read_hold_a: assert property (start |-> DATA_OE throughout (!RD_N [*3]))
    else $error("Bus dropped inside read");
  cfg_read_zero_a: assert property (start && PORT_SELECT == 2'h3 |-> ##2 DATA_OUT == 8'h00)
    else $error("Configuration port readable");
  data_stands_a: assert property (!$past(start) && !$past(start, 2) |-> $stable(DATA_OUT))
    else $error("Read data changed outside read start");
  mode0_low_a: assert property (cfg_wr && DATA_IN[7:6] == 2'h1 && DATA_IN[5:4] != 2'h0
    && DATA_IN[3:1] == 3'h0 |-> ##[1:3] !OUT[1])
    else $error("Mode zero output not low");
  out_quiet_a: assert property (quiet >= 4'h8 |-> $stable(OUT))
    else $error("Output moved without tick");
  cover property (start && PORT_SELECT == 2'h0);
  cover property (cfg_wr && DATA_IN[5:4] == 2'h0);
  cover property ($rose(OUT[1]));
endmodule
`default_nettype wire

// File: test/interval_host_model.sv
// Processor bus master model
`timescale 1ns/1ps
`default_nettype none
module interval_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [1:0] port_select,
  output logic [7:0] bus_data,
  input wire logic [7:0] rdata
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select = 2'h0;
    bus_data = 8'h5a;
  end
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic sel);
    @(posedge clk);
    cs_n <= !sel;
    wr_n <= 1'b0;
    port_select <= a;
    bus_data <= d;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    bus_data <= ~d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    port_select <= a;
    repeat (3) @(posedge clk);
    d = rdata;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: test/interval_timer_host_interface_tb.sv
// Testbench of the interval timer host interface
`timescale 1ns/1ps
`default_nettype none
module interval_timer_host_interface_tb;
  logic CLK, RESET, CS_N, RD_N, WR_N, DATA_OE;
  logic [1:0] PORT_SELECT;
  logic [7:0] DATA_IN, DATA_OUT, bus_data, b;
  logic [2:0] TICK_CLK, GATE, OUT;
  logic [15:0] v;
  int n_fail, checks, cyc;
  assign DATA_IN = DATA_OE ? DATA_OUT : bus_data;
  interval_timer_host_interface #(.CHANNELS(3)) i_dut (.CLK(CLK), .RESET(RESET),
    .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .PORT_SELECT(PORT_SELECT),
    .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
    .TICK_CLK(TICK_CLK), .GATE(GATE), .OUT(OUT));
  interval_host_model i_host (.clk(CLK), .cs_n(CS_N), .rd_n(RD_N), .wr_n(WR_N),
    .port_select(PORT_SELECT), .bus_data(bus_data), .rdata(DATA_OUT));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // ****
  // Tasks
  // ****
  task results;
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task rd16(input logic [1:0] a, output logic [15:0] d);
    logic [7:0] lo, hi;
    i_host.rd(a, lo);
    i_host.rd(a, hi);
    d = {hi, lo};
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge CLK);
      TICK_CLK <= 3'h7;
      repeat (2) @(posedge CLK);
      TICK_CLK <= 3'h0;
      repeat (3) @(posedge CLK);
    end
  endtask
  task gate(input logic [2:0] g);
    @(posedge CLK);
    GATE <= g;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      results();
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    n_fail = 0;
    checks = 0;
    cyc = 0;
    RESET = 1'b1;
    TICK_CLK = 3'h0;
    GATE = 3'h0;
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    i_host.wr(2'h3, 8'h30, 1'b1);
    i_host.wr(2'h0, 8'h34, 1'b1);
    i_host.wr(2'h0, 8'h12, 1'b1);
    i_host.wr(2'h3, 8'h50, 1'b1);
    i_host.wr(2'h1, 8'h03, 1'b1);
    tick(2);
    cmp("out1 armed", 16'h0000, {15'h0000, OUT[1]});
    rd16(2'h0, v);
    cmp("ch0 count", 16'h1234, v);
    i_host.wr(2'h3, 8'h00, 1'b1);
    gate(3'h3);
    tick(3);
    i_host.wr(2'h3, 8'h00, 1'b1);
    tick(2);
    cmp("out1 expired", 16'h0001, {15'h0000, OUT[1]});
    rd16(2'h0, v);
    cmp("ch0 latched", 16'h1234, v);
    gate(3'h0);
    rd16(2'h0, v);
    cmp("ch0 tracking", 16'h122f, v);
    i_host.wr(2'h3, 8'h00, 1'b0);
    gate(3'h1);
    tick(1);
    gate(3'h0);
    rd16(2'h0, v);
    cmp("ch0 deselected", 16'h122e, v);
    i_host.wr(2'h3, 8'he2, 1'b1);
    i_host.rd(2'h0, b);
    cmp("ch0 status", 16'h0030, {8'h00, b});
    i_host.rd(2'h1, b);
    cmp("ch1 count", 16'h00fe, {8'h00, b});
    i_host.rd(2'h3, b);
    cmp("config read", 16'h0000, {8'h00, b});
    i_host.wr(2'h3, 8'h94, 1'b1);
    i_host.wr(2'h2, 8'h03, 1'b1);
    gate(3'h4);
    tick(3);
    cmp("out2 rate low", 16'h0000, {15'h0000, OUT[2]});
    tick(1);
    cmp("out2 rate high", 16'h0001, {15'h0000, OUT[2]});
    results();
  end
endmodule
bind interval_timer_host_interface interval_timer_host_interface_properties
  #(.CHANNELS(CHANNELS)) i_props (.CLK(CLK), .RESET(RESET), .CS_N(CS_N),
  .RD_N(RD_N), .WR_N(WR_N), .PORT_SELECT(PORT_SELECT), .DATA_IN(DATA_IN),
  .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .TICK_CLK(TICK_CLK), .GATE(GATE),
  .OUT(OUT));
`default_nettype wire
